// >>> core/eau_top.sv
// effective address unit: mode legality, address arithmetic, writeback
// assumes decoder holds request fields stable while req_valid is high and
// that register file data answers reg_rd_idx in the same cycle
module eau_top
	import eau_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	input  wire logic              adv_mode_strap,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire eau_cls_t          req_cls,
	input  wire eau_mode_t         req_mode,
	input  wire eau_size_t         req_size,
	input  wire eau_bitop_t        req_bitop,
	input  wire logic              req_bit_from_reg,
	input  wire logic [3:0]        req_reg,
	input  wire logic [ADDR_W-1:0] req_ext,
	input  wire logic [BIT_IDX_W-1:0] req_imm3,
	input  wire logic [PC_W-1:0]   req_pc_next,
	output logic [REG_IDX_W-1:0]   reg_rd_idx,
	input  wire logic [ADDR_W-1:0] reg_rd_data,
	input  wire logic [BYTE_W-1:0] bit_reg_data,
	output logic                   rd_req,
	output logic [ADDR_W-1:0]      rd_addr,
	output logic                   rd_long,
	input  wire logic              rd_ack,
	input  wire logic [ADDR_W-1:0] rd_data,
	output logic                   ea_valid,
	output logic                   ea_unsup,
	output logic                   ea_is_mem,
	output logic [ADDR_W-1:0]      ea_addr,
	output logic [ADDR_W-1:0]      op_val,
	output logic [BIT_IDX_W-1:0]   bit_idx,
	output logic [TRAP_W-1:0]      trap_vec,
	output logic                   wb_en,
	output logic [REG_IDX_W-1:0]   wb_idx,
	output logic [ADDR_W-1:0]      wb_data,
	output logic                   adv_mode
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		eau_state_t            state;
		logic                  cap;
		logic                  adv;
		logic                  valid;
		logic                  unsup;
		logic                  is_mem;
		logic [ADDR_W-1:0]     addr;
		logic [ADDR_W-1:0]     opv;
		logic [BIT_IDX_W-1:0]  bidx;
		logic [TRAP_W-1:0]     trap;
		logic                  wb;
		logic [REG_IDX_W-1:0]  wbi;
		logic [ADDR_W-1:0]     wbd;
		logic                  rreq;
		logic [ADDR_W-1:0]     raddr;
		logic                  rlong;
	} eau_st_t;

	localparam eau_st_t ST_RST = '{state: ST_IDLE, cap: 1'b0, adv: 1'b0,
		valid: 1'b0, unsup: 1'b0, is_mem: 1'b0, addr: ADDR_RST,
		opv: ADDR_RST, bidx: '0, trap: '0, wb: 1'b0, wbi: '0,
		wbd: ADDR_RST, rreq: 1'b0, raddr: ADDR_RST, rlong: 1'b0};

	eau_st_t s_q;
	eau_st_t s_d;
	logic    acc;

	eau_view_if vw ();

	eau_reg_view u_view (
		.vw (vw.view)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic eau_legal(input eau_cls_t c,
		input eau_mode_t m, input eau_bitop_t b, input logic fr);
		logic ok;
		ok = 1'b0;
		case (c)
			CL_ALU: ok = (m == MD_REG_DIRECT) || (m == MD_IMM);
			// move mode set, no 24-bit data form
			CL_MOVE: ok = !((m == MD_PC_REL8) || (m == MD_PC_REL16) ||
				(m == MD_MEM_IND) || (m == MD_ABS24));
			CL_BIT: ok = ((m == MD_REG_DIRECT) || (m == MD_REG_IND) ||
				(m == MD_ABS8) || (m == MD_ABS16) || (m == MD_ABS32)) &&
				(!fr || (b != BO_OTHER));
			CL_BRANCH: ok = (m == MD_PC_REL8) || (m == MD_PC_REL16);
			CL_JUMP: ok = (m == MD_REG_IND) || (m == MD_ABS24) ||
				(m == MD_MEM_IND);
			CL_PTR: ok = (m == MD_REG_DIRECT);
			CL_TRAP: ok = (m == MD_IMM);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	function automatic logic [ADDR_W-1:0] eau_finish(
		input logic [ADDR_W-1:0] a, input logic even, input logic adv);
		logic [ADDR_W-1:0] r;
		r = even ? (a & EVEN_MASK) : a;
		if (!adv) begin
			r = r & NORM_MASK;
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// no request until the mode is captured
	assign req_ready  = (s_q.state == ST_IDLE) && s_q.cap;
	assign acc        = req_valid && req_ready;
	assign reg_rd_idx = req_reg[REG_IDX_W-1:0];

	assign vw.long_val = reg_rd_data;
	assign vw.size     = req_size;
	// byte field: clear half bit picks the high byte register
	assign vw.upper    = (req_size == SZ_BYTE) ? !req_reg[REG_HALF] :
		req_reg[REG_HALF];

	always_comb begin
		logic [ADDR_W-1:0] raw;
		logic              even;
		logic [ADDR_W-1:0] step;
		raw  = ADDR_RST;
		even = 1'b0;
		step = eau_step(req_size);
		s_d  = s_q;
		s_d.valid = 1'b0;
		s_d.unsup = 1'b0;
		s_d.wb    = 1'b0;
		if (!s_q.cap) begin
			s_d.cap = 1'b1;
			s_d.adv = adv_mode_strap;
		end
		case (s_q.state)
			ST_IDLE: begin
				if (acc && !eau_legal(req_cls, req_mode, req_bitop,
					req_bit_from_reg)) begin
					s_d.unsup = 1'b1;
				end else if (acc) begin
					s_d.valid  = 1'b1;
					s_d.is_mem = 1'b1;
					s_d.wbi    = req_reg[REG_IDX_W-1:0];
					s_d.bidx   = req_bit_from_reg ?
						bit_reg_data[BIT_IDX_W-1:0] : req_imm3;
					s_d.trap   = req_ext[TRAP_W-1:0];
					s_d.opv    = ADDR_RST;
					even = (req_size != SZ_BYTE) ||
						(req_cls == CL_JUMP) || (req_cls == CL_BRANCH);
					case (req_mode)
						MD_REG_DIRECT: begin
							s_d.is_mem = 1'b0;
							s_d.opv    = vw.view_val;
						end
						MD_REG_IND: begin
							raw = (req_cls == CL_JUMP) ?
								(reg_rd_data & PROG_MASK) : reg_rd_data;
						end
						MD_DISP16: raw = reg_rd_data +
							{{(ADDR_W-WORD_W){req_ext[WORD_W-1]}},
							 req_ext[WORD_W-1:0]};
						MD_DISP32: raw = reg_rd_data + req_ext;
						MD_POST_INC: begin
							raw = reg_rd_data;
							s_d.wb  = 1'b1;
							s_d.wbd = reg_rd_data + step;
						end
						MD_PRE_DEC: begin
							// decremented value is address and writeback
							raw = reg_rd_data - step;
							s_d.wb  = 1'b1;
							s_d.wbd = reg_rd_data - step;
						end
						MD_ABS8: raw = {ABS8_FILL, req_ext[BYTE_W-1:0]};
						MD_ABS16: raw = {{(ADDR_W-WORD_W){req_ext[WORD_W-1]}},
							req_ext[WORD_W-1:0]};
						MD_ABS24: raw = req_ext & PROG_MASK;
						MD_ABS32: raw = req_ext;
						MD_IMM: begin
							s_d.is_mem = 1'b0;
							case (req_size)
								SZ_BYTE: s_d.opv = req_ext & PTR_MASK;
								SZ_WORD: s_d.opv = req_ext & NORM_MASK;
								default: s_d.opv = req_ext;
							endcase
						end
						MD_PC_REL8, MD_PC_REL16: begin
							raw = ({PROG_FILL, req_pc_next} +
								((req_mode == MD_PC_REL8) ?
								{{(ADDR_W-BYTE_W){req_ext[BYTE_W-1]}},
								 req_ext[BYTE_W-1:0]} :
								{{(ADDR_W-WORD_W){req_ext[WORD_W-1]}},
								 req_ext[WORD_W-1:0]})) & PROG_MASK;
						end
						MD_MEM_IND: begin
							s_d.valid = 1'b0;
							s_d.rreq  = 1'b1;
							s_d.rlong = s_q.adv;
							s_d.raddr = eau_finish(req_ext & PTR_MASK,
								1'b1, s_q.adv);
							s_d.state = ST_IND;
						end
						default: s_d.unsup = 1'b1;
					endcase
					if (req_mode == MD_PC_REL8 || req_mode == MD_PC_REL16 ||
						req_cls == CL_JUMP) begin
						s_d.is_mem = 1'b0;
					end
					s_d.addr = eau_finish(raw, even, s_q.adv);
				end
			end
			ST_IND: begin
				if (rd_ack) begin
					// word target or long with zero top byte
					raw = s_q.adv ? (rd_data & PROG_MASK) :
						(rd_data & NORM_MASK);
					s_d.addr   = eau_finish(raw, 1'b1, s_q.adv);
					s_d.valid  = 1'b1;
					s_d.is_mem = 1'b0;
					s_d.rreq   = 1'b0;
					s_d.state  = ST_IDLE;
				end
			end
			default: s_d.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_q <= ST_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign ea_valid  = s_q.valid;
	assign ea_unsup  = s_q.unsup;
	assign ea_is_mem = s_q.is_mem;
	assign ea_addr   = s_q.addr;
	assign op_val    = s_q.opv;
	assign bit_idx   = s_q.bidx;
	assign trap_vec  = s_q.trap;
	assign wb_en     = s_q.wb;
	assign wb_idx    = s_q.wbi;
	assign wb_data   = s_q.wbd;
	assign rd_req    = s_q.rreq;
	assign rd_addr   = s_q.raddr;
	assign rd_long   = s_q.rlong;
	assign adv_mode  = s_q.adv;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_ind_start;
		acc && req_cls == CL_JUMP && req_mode == MD_MEM_IND;
	endsequence
	sequence s_ind_done;
		rd_req && rd_ack;
	endsequence

	a_alu_modes: assert property (acc && req_cls == CL_ALU &&
		req_mode != MD_REG_DIRECT && req_mode != MD_IMM
		|=> ea_unsup && !ea_valid) else $error("alu mode accepted");
	a_move_modes: assert property (acc && req_cls == CL_MOVE &&
		(req_mode == MD_PC_REL8 || req_mode == MD_MEM_IND)
		|=> ea_unsup) else $error("move mode accepted");
	a_bit_index: assert property (acc && req_cls == CL_BIT &&
		req_bit_from_reg && req_bitop == BO_OTHER
		|=> ea_unsup) else $error("register bit index accepted");
	a_post_inc: assert property (acc && req_cls == CL_MOVE &&
		req_mode == MD_POST_INC && req_size == SZ_BYTE && adv_mode
		|=> wb_en && ea_addr == $past(reg_rd_data) &&
		wb_data == $past(reg_rd_data) + STEP_BYTE)
		else $error("post-increment wrong");
	a_pre_dec: assert property (acc && req_cls == CL_MOVE &&
		req_mode == MD_PRE_DEC && req_size == SZ_LONG && adv_mode
		|=> wb_en && wb_data == $past(reg_rd_data) - STEP_LONG &&
		ea_addr == (wb_data & EVEN_MASK)) else $error("pre-decrement wrong");
	a_abs8_page: assert property (acc && req_cls == CL_MOVE &&
		req_mode == MD_ABS8 && adv_mode
		|=> ea_valid && ea_addr[ADDR_W-1:BYTE_W] == ABS8_FILL)
		else $error("short absolute not in top page");
	a_branch_even: assert property (acc && req_cls == CL_BRANCH &&
		req_mode == MD_PC_REL8
		|=> ea_valid && ea_addr[0] == 1'b0 &&
		ea_addr[ADDR_W-1:PC_W] == PROG_FILL)
		else $error("branch target malformed");
	a_norm_width: assert property (ea_valid && !adv_mode
		|-> ea_addr[ADDR_W-1:WORD_W] == '0)
		else $error("normal mode address too wide");
	a_ind_read: assert property (s_ind_start
		|=> rd_req && rd_long == adv_mode &&
		rd_addr[ADDR_W-1:BYTE_W] == '0) else $error("indirect read wrong");
	a_ind_target: assert property (s_ind_done ##0 adv_mode
		|=> ea_valid && !rd_req && ea_addr[ADDR_W-1:PC_W] == PROG_FILL)
		else $error("indirect target wrong");
	// a second pulse is only legal for a freshly accepted operand
	a_wb_once: assert property (wb_en
		|-> ea_valid ##1 (!wb_en || $past(acc)))
		else $error("writeback repeated");
	a_abs16_sext: assert property (acc && req_cls == CL_MOVE &&
		req_mode == MD_ABS16 && adv_mode
		|=> ea_valid &&
		ea_addr[ADDR_W-1:WORD_W] == {(ADDR_W-WORD_W){ea_addr[WORD_W-1]}})
		else $error("absolute word not sign extended");
	a_abs24_fill: assert property (acc && req_cls == CL_JUMP &&
		req_mode == MD_ABS24
		|=> ea_valid && !ea_addr[0] && ea_addr[ADDR_W-1:PC_W] == PROG_FILL)
		else $error("program target malformed");
	a_imm_width: assert property (acc && req_cls == CL_ALU &&
		req_mode == MD_IMM && req_size == SZ_BYTE
		|=> ea_valid && !ea_is_mem && op_val[ADDR_W-1:BYTE_W] == '0)
		else $error("byte immediate too wide");
	a_busy_ready: assert property (rd_req |-> !req_ready)
		else $error("request accepted during pointer read");
	a_mode_hold: assert property (req_ready |=> $stable(adv_mode))
		else $error("address mode changed");

endmodule

// >>> core/eau_pkg.sv
// constants, types and helpers of the effective address unit
// assumes one clock domain; used by the unit and its register view
// Contract
// - ALU operations accept only register direct or immediate operands.
// - moves accept every mode except pc relative, memory indirect and 24-bit absolute.
// - bit ops: direct, indirect, absolute; register index only set/clr/inv/tst.
// - register direct picks byte, word or long register view by size.
// - indirect address used as fetch target keeps low 24 bits only.
// - displacement added to register; 16-bit one sign-extended first.
// - post-increment: access at register, then write back register plus 1/2/4.
// - pre-decrement: register minus 1/2/4 is address and written back.
// - 8-bit absolute data address gets upper 24 bits all ones.
// - 16-bit absolute data address is sign-extended.
// - 32-bit absolute data address is used unchanged.
// - 24-bit absolute is a fetch target only, upper 8 bits zero.
// - immediates 8/16/32 bits; pointer ops implicit; trap has 2-bit vector.
// - branch: sign-extended displacement plus 24-bit pc, upper 8 bits zero.
// - branch base is the address of the next instruction's first byte.
// - memory indirect for jumps only, 8-bit pointer zero-extended.
// - memory indirect reads word in normal, longword with zero top byte in advanced.
// - word, long and branch target addresses have bit 0 cleared.
// - normal mode drops upper address bits, leaving a 16-bit address.
package eau_pkg;

	// ------------------------------------------------------------
	// widths and masks
	// ------------------------------------------------------------
	localparam int ADDR_W      = 32;
	localparam int PC_W        = 24;
	localparam int BYTE_W      = 8;
	localparam int WORD_W      = 16;
	localparam int REG_IDX_W   = 3;
	localparam int REG_HALF    = 3;
	localparam int BIT_IDX_W   = 3;
	localparam int TRAP_W      = 2;

	localparam logic [ADDR_W-1:0] ADDR_RST  = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] EVEN_MASK = 32'hFFFF_FFFE;
	localparam logic [ADDR_W-1:0] NORM_MASK = 32'h0000_FFFF;
	localparam logic [ADDR_W-1:0] PROG_MASK = 32'h00FF_FFFF;
	localparam logic [ADDR_W-1:0] PTR_MASK  = 32'h0000_00FF;
	localparam logic [ADDR_W-BYTE_W-1:0] ABS8_FILL = 24'hFFFFFF;
	localparam logic [ADDR_W-PC_W-1:0]   PROG_FILL = 8'h00;

	localparam logic [ADDR_W-1:0] STEP_BYTE = 32'h0000_0001;
	localparam logic [ADDR_W-1:0] STEP_WORD = 32'h0000_0002;
	localparam logic [ADDR_W-1:0] STEP_LONG = 32'h0000_0004;

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		MD_REG_DIRECT = 4'b0000,
		MD_REG_IND    = 4'b0001,
		MD_DISP16     = 4'b0010,
		MD_DISP32     = 4'b0011,
		MD_POST_INC   = 4'b0100,
		MD_PRE_DEC    = 4'b0101,
		MD_ABS8       = 4'b0110,
		MD_ABS16      = 4'b0111,
		MD_ABS24      = 4'b1000,
		MD_ABS32      = 4'b1001,
		MD_IMM        = 4'b1010,
		MD_PC_REL8    = 4'b1011,
		MD_PC_REL16   = 4'b1100,
		MD_MEM_IND    = 4'b1101
	} eau_mode_t;

	typedef enum logic [2:0] {
		CL_ALU    = 3'b000,
		CL_MOVE   = 3'b001,
		CL_BIT    = 3'b010,
		CL_BRANCH = 3'b011,
		CL_JUMP   = 3'b100,
		CL_PTR    = 3'b101,
		CL_TRAP   = 3'b110
	} eau_cls_t;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'b00,
		SZ_WORD = 2'b01,
		SZ_LONG = 2'b10
	} eau_size_t;

	typedef enum logic [2:0] {
		BO_SET   = 3'b000,
		BO_CLR   = 3'b001,
		BO_INV   = 3'b010,
		BO_TST   = 3'b011,
		BO_OTHER = 3'b100
	} eau_bitop_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_IND  = 2'b01
	} eau_state_t;

	function automatic logic [ADDR_W-1:0] eau_step(input eau_size_t sz);
		case (sz)
			SZ_BYTE: eau_step = STEP_BYTE;
			SZ_WORD: eau_step = STEP_WORD;
			default: eau_step = STEP_LONG;
		endcase
	endfunction

endpackage

// >>> core/eau_view_if.sv
// carrier between the unit and its register view
// assumes the long register value is already read from the register file
interface eau_view_if;
	import eau_pkg::*;
	logic [ADDR_W-1:0] long_val;
	eau_size_t         size;
	logic              upper;
	logic [ADDR_W-1:0] view_val;
	modport src  (output long_val, output size, output upper,
		input view_val);
	modport view (input long_val, input size, input upper,
		output view_val);
endinterface

// >>> core/eau_reg_view.sv
// register direct view: byte, word or long slice of a long register
// assumes the caller sets upper from the register field and size
module eau_reg_view
	import eau_pkg::*;
(
	eau_view_if.view vw
);

	always_comb begin
		case (vw.size)
			SZ_BYTE: begin
				vw.view_val = vw.upper ?
					{{(ADDR_W-BYTE_W){1'b0}},
					 vw.long_val[2*BYTE_W-1:BYTE_W]} :
					{{(ADDR_W-BYTE_W){1'b0}}, vw.long_val[BYTE_W-1:0]};
			end
			SZ_WORD: begin
				vw.view_val = vw.upper ?
					{{(ADDR_W-WORD_W){1'b0}},
					 vw.long_val[ADDR_W-1:WORD_W]} :
					{{(ADDR_W-WORD_W){1'b0}}, vw.long_val[WORD_W-1:0]};
			end
			default: vw.view_val = vw.long_val;
		endcase
	end

endmodule

// >>> testbench/eau_far_model.sv
// far side of the unit: register file read port and memory read bus
// assumes the unit holds rd_req, rd_addr and rd_long until rd_ack
module eau_far_model
	import eau_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	input  wire logic [3:0]           lat,
	input  wire logic [REG_IDX_W-1:0] reg_rd_idx,
	output logic [ADDR_W-1:0]         reg_rd_data,
	output logic [BYTE_W-1:0]         bit_reg_data,
	input  wire logic                 rd_req,
	input  wire logic [ADDR_W-1:0]    rd_addr,
	input  wire logic                 rd_long,
	output logic                      rd_ack,
	output logic [ADDR_W-1:0]         rd_data,
	output logic [ADDR_W-1:0]         last_addr,
	output logic                      last_long
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------
	// register file and pointer memory
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] MEM_WORD = 32'hEE5A_C301;
	logic [3:0] cnt_q;
	assign reg_rd_data = 32'h8765_4320 + {28'h0, reg_rd_idx, 1'b0};
	assign bit_reg_data = 8'hF5;
	// a released data line shows the inverse, never a stale copy
	assign rd_data = rd_ack ? MEM_WORD : ~MEM_WORD;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 4'h0;
			rd_ack <= 1'b0;
			last_addr <= 32'h0;
			last_long <= 1'b0;
		end else begin
			rd_ack <= 1'b0;
			if (rd_req && !rd_ack) begin
				if (cnt_q == lat) begin
					rd_ack <= 1'b1;
					cnt_q <= 4'h0;
					last_addr <= rd_addr;
					last_long <= rd_long;
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
	end
endmodule

// >>> testbench/testbench.sv
// self-checking bench of the effective address unit
// assumes the far side model answers register reads and pointer reads
module testbench
	import eau_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic resetn, adv_mode_strap, req_valid, req_ready, req_bit_from_reg;
	eau_cls_t req_cls;
	eau_mode_t req_mode;
	eau_size_t req_size;
	eau_bitop_t req_bitop;
	logic [3:0] req_reg, lat;
	logic [ADDR_W-1:0] req_ext, reg_rd_data, rd_addr, rd_data, ea_addr;
	logic [ADDR_W-1:0] op_val, wb_data, last_addr;
	logic [BIT_IDX_W-1:0] req_imm3, bit_idx;
	logic [PC_W-1:0] req_pc_next;
	logic [REG_IDX_W-1:0] reg_rd_idx, wb_idx;
	logic [BYTE_W-1:0] bit_reg_data;
	logic rd_req, rd_long, rd_ack, ea_valid, ea_unsup, ea_is_mem;
	logic wb_en, adv_mode, last_long;
	logic [TRAP_W-1:0] trap_vec;
	int fails = 0;
	int check_count = 0;

	always #12.5 clk_sys = ~clk_sys;

	eau_top DUT (.clk_sys, .resetn, .adv_mode_strap, .req_valid, .req_ready,
		.req_cls, .req_mode, .req_size, .req_bitop, .req_bit_from_reg,
		.req_reg, .req_ext, .req_imm3, .req_pc_next, .reg_rd_idx,
		.reg_rd_data, .bit_reg_data, .rd_req, .rd_addr, .rd_long, .rd_ack,
		.rd_data, .ea_valid, .ea_unsup, .ea_is_mem, .ea_addr, .op_val,
		.bit_idx, .trap_vec, .wb_en, .wb_idx, .wb_data, .adv_mode);
	eau_far_model far (.clk_sys, .resetn, .lat, .reg_rd_idx, .reg_rd_data,
		.bit_reg_data, .rd_req, .rd_addr, .rd_long, .rd_ack, .rd_data,
		.last_addr, .last_long);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task final_report;
		$display("mismatches %0d comparisons %0d", fails, check_count);
		if (fails == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [31:0] rv(int i);
		rv = 32'h8765_4320 + 32'(2 * i);
	endfunction

	task automatic rst(logic v);
		@(posedge clk_sys);
		resetn <= 1'b0;
		adv_mode_strap <= v;
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic req(eau_cls_t c, eau_mode_t m, eau_size_t s,
		logic [3:0] r, logic [31:0] x, eau_bitop_t b = BO_SET,
		logic fr = 1'b0, logic [23:0] pc = 24'h0);
		int n;
		@(posedge clk_sys);
		req_cls <= c;
		req_mode <= m;
		req_size <= s;
		req_reg <= r;
		req_ext <= x;
		req_bitop <= b;
		req_bit_from_reg <= fr;
		req_pc_next <= pc;
		req_valid <= 1'b1;
		n = 0;
		@(negedge clk_sys);
		while (req_ready !== 1'b1 && n < 50) begin
			n++;
			@(negedge clk_sys);
		end
		@(posedge clk_sys);
		req_valid <= 1'b0;
		@(negedge clk_sys);
		while (ea_valid !== 1'b1 && ea_unsup !== 1'b1 && n < 50) begin
			n++;
			@(negedge clk_sys);
		end
		if (n >= 50) begin
			fails++;
			final_report;
		end
	endtask

	task automatic ea(eau_cls_t c, eau_mode_t m, eau_size_t s,
		logic [3:0] r, logic [31:0] x, logic [31:0] e,
		logic [23:0] pc = 24'h0);
		req(c, m, s, r, x, BO_SET, 1'b0, pc);
		chk("ea_addr", e, ea_addr);
	endtask

	function automatic bit legal(eau_cls_t c, eau_mode_t m);
		case (c)
			CL_ALU:    legal = m inside {MD_REG_DIRECT, MD_IMM};
			CL_MOVE:   legal = !(m inside {MD_PC_REL8, MD_PC_REL16,
				MD_MEM_IND, MD_ABS24});
			CL_BIT:    legal = m inside {MD_REG_DIRECT, MD_REG_IND,
				MD_ABS8, MD_ABS16, MD_ABS32};
			CL_BRANCH: legal = m inside {MD_PC_REL8, MD_PC_REL16};
			CL_JUMP:   legal = m inside {MD_REG_IND, MD_ABS24, MD_MEM_IND};
			CL_PTR:    legal = m == MD_REG_DIRECT;
			default:   legal = m == MD_IMM;
		endcase
	endfunction

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_legal;
		for (int c = 0; c < 7; c++)
			for (int m = 0; m < 14; m++) begin
				req(eau_cls_t'(c), eau_mode_t'(m), SZ_BYTE, 4'h0, 32'h0);
				chk("ea_unsup", 32'(!legal(eau_cls_t'(c), eau_mode_t'(m))),
					32'(ea_unsup));
				if (ea_unsup === 1'b1)
					chk("wb_en", 32'h0, 32'(wb_en));
			end
	endtask

	task automatic t_regview;
		req(CL_MOVE, MD_REG_DIRECT, SZ_BYTE, 4'h1, 32'h0);
		chk("byte_high", 32'h43, op_val);
		req(CL_MOVE, MD_REG_DIRECT, SZ_BYTE, 4'h9, 32'h0);
		chk("byte_low", 32'h22, op_val);
		req(CL_MOVE, MD_REG_DIRECT, SZ_WORD, 4'h1, 32'h0);
		chk("word_low", 32'h4322, op_val);
		req(CL_MOVE, MD_REG_DIRECT, SZ_WORD, 4'h9, 32'h0);
		chk("word_up", 32'h8765, op_val);
		req(CL_MOVE, MD_REG_DIRECT, SZ_LONG, 4'h1, 32'h0);
		chk("long", rv(1), op_val);
	endtask

	task automatic t_step;
		logic [31:0] st;
		for (int s = 0; s < 3; s++) begin
			st = 32'h1 << s;
			req(CL_MOVE, MD_POST_INC, eau_size_t'(s), 4'h2, 32'h0);
			chk("post_addr", rv(2), ea_addr);
			chk("post_wb", 32'h1, 32'(wb_en));
			chk("post_wbd", rv(2) + st, wb_data);
			chk("wb_idx", 32'h2, 32'(wb_idx));
			@(negedge clk_sys);
			chk("wb_once", 32'h0, 32'(wb_en));
			req(CL_MOVE, MD_PRE_DEC, eau_size_t'(s), 4'h2, 32'h0);
			chk("pre_addr", rv(2) - st, ea_addr);
			chk("pre_wbd", rv(2) - st, wb_data);
			chk("pre_wb", 32'h1, 32'(wb_en));
			chk("is_mem", 32'h1, 32'(ea_is_mem));
		end
	endtask

	task automatic t_addr;
		ea(CL_MOVE, MD_DISP16, SZ_BYTE, 4'h3, 32'h0000_FFF0,
			32'h8765_4316);
		ea(CL_MOVE, MD_DISP32, SZ_WORD, 4'h3, 32'h1000_0001,
			32'h9765_4326);
		ea(CL_MOVE, MD_ABS8, SZ_BYTE, 4'h0, 32'h0000_1234,
			32'hFFFF_FF34);
		ea(CL_MOVE, MD_ABS16, SZ_BYTE, 4'h0, 32'h0000_8000,
			32'hFFFF_8000);
		ea(CL_MOVE, MD_ABS16, SZ_BYTE, 4'h0, 32'h0000_7FFF,
			32'h0000_7FFF);
		ea(CL_MOVE, MD_ABS32, SZ_BYTE, 4'h0, 32'h1234_5679,
			32'h1234_5679);
		ea(CL_JUMP, MD_ABS24, SZ_BYTE, 4'h0, 32'hAB12_3457,
			32'h0012_3456);
		ea(CL_JUMP, MD_REG_IND, SZ_BYTE, 4'h3, 32'h0, 32'h0065_4326);
		ea(CL_MOVE, MD_REG_IND, SZ_BYTE, 4'h3, 32'h0, 32'h8765_4326);
		ea(CL_BRANCH, MD_PC_REL8, SZ_BYTE, 4'h0, 32'h80, 32'h80,
			24'h000100);
		ea(CL_BRANCH, MD_PC_REL16, SZ_BYTE, 4'h0, 32'h7FFF,
			32'h0000_7FEE, 24'hFFFFF0);
		chk("is_mem", 32'h0, 32'(ea_is_mem));
	endtask

	task automatic t_imm;
		req(CL_ALU, MD_IMM, SZ_BYTE, 4'h0, 32'hDEAD_BEA5);
		chk("imm8", 32'hA5, op_val);
		req(CL_ALU, MD_IMM, SZ_WORD, 4'h0, 32'hDEAD_BEA5);
		chk("imm16", 32'hBEA5, op_val);
		req(CL_ALU, MD_IMM, SZ_LONG, 4'h0, 32'hDEAD_BEA5);
		chk("imm32", 32'hDEAD_BEA5, op_val);
		req(CL_TRAP, MD_IMM, SZ_BYTE, 4'h0, 32'h0000_0006);
		chk("trap_vec", 32'h2, 32'(trap_vec));
	endtask

	task automatic t_bits;
		for (int b = 0; b < 5; b++) begin
			req(CL_BIT, MD_REG_DIRECT, SZ_BYTE, 4'h0, 32'h0,
				eau_bitop_t'(b), 1'b1);
			chk("bit_unsup", 32'(b == 4), 32'(ea_unsup));
			if (b < 4)
				chk("bit_reg", 32'h5, 32'(bit_idx));
		end
		req(CL_BIT, MD_REG_DIRECT, SZ_BYTE, 4'h0, 32'h0, BO_OTHER, 1'b0);
		chk("bit_imm", 32'h2, 32'(bit_idx));
	endtask

	task automatic t_memind(logic adv);
		lat <= adv ? 4'h3 : 4'h0;
		ea(CL_JUMP, MD_MEM_IND, SZ_BYTE, 4'h0, 32'h0000_1281,
			adv ? 32'h005A_C300 : 32'h0000_C300);
		chk("ptr_addr", 32'h80, last_addr);
		chk("ptr_long", 32'(adv), 32'(last_long));
	endtask

	task automatic t_normal;
		rst(1'b0);
		chk("adv_mode", 32'h0, 32'(adv_mode));
		ea(CL_MOVE, MD_ABS8, SZ_BYTE, 4'h0, 32'h1234,
			32'h0000_FF34);
		ea(CL_MOVE, MD_ABS16, SZ_BYTE, 4'h0, 32'h8000,
			32'h0000_8000);
		t_memind(1'b0);
		ea(CL_MOVE, MD_POST_INC, SZ_WORD, 4'h2, 32'h0,
			32'h0000_4324);
		chk("wb_full", rv(2) + 2, wb_data);
		@(posedge clk_sys);
		adv_mode_strap <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("adv_hold", 32'h0, 32'(adv_mode));
	endtask

	initial begin
		{resetn, adv_mode_strap, req_valid, req_bit_from_reg} = 4'h0;
		req_cls = CL_ALU;
		req_mode = MD_REG_DIRECT;
		req_size = SZ_BYTE;
		req_bitop = BO_SET;
		{req_reg, lat, req_ext, req_pc_next} = '0;
		req_imm3 = 3'h2;
		rst(1'b1);
		chk("adv_mode", 32'h1, 32'(adv_mode));
		t_legal;
		t_regview;
		t_step;
		t_addr;
		t_imm;
		t_bits;
		t_memind(1'b1);
		t_normal;
		final_report;
	end
endmodule
